// [logic/pwr_ctl_pkg.sv]
// Shared constants and types for the power-saving mode controller
package pwr_ctl_pkg;
	localparam int OSC_SEL_W = 3;
	localparam int OSC_CTL_W = 16;
	localparam int NEW_OSC_LSB = 8;
	localparam int NEW_OSC_MSB = 10;
	localparam int SWITCH_REQ_BIT = 0;
	localparam logic [2:0] OSC_SEL_RST = 3'h0;
	localparam logic [15:0] OSC_CTL_RST = 16'h0000;
	localparam logic PS_MODE_SLEEP = 1'b0;
	localparam logic PS_MODE_IDLE = 1'b1;
	// Nanoseconds spent settling a newly selected oscillator
	localparam int SWITCH_TIME_NS = 50;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SWITCH_CYCLES =
		(SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SWITCH_CNT_MAX = 4'(SWITCH_CYCLES - 1);
	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_SLEEP
	} pwr_state_t;
endpackage : pwr_ctl_pkg

// [logic/osc_switch_ctl.sv]
// Oscillator control register with unlock-gated writes and switch sequencing
`timescale 1ns/10ps
module osc_switch_ctl
	import pwr_ctl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic unlocked_in,
	input wire logic cfg_locked_in,
	input wire logic wr_in,
	input wire logic [15:0] wr_data_in,
	output logic [2:0] active_osc_out,
	output logic [15:0] osc_ctl_out
);
	logic [2:0] new_osc_q;
	logic switch_q;
	logic [2:0] active_q;
	logic [3:0] cnt_q;
	logic wr_ok;

	// Writes without the unlock sequence are dropped
	assign wr_ok = wr_in && unlocked_in && !cfg_locked_in; // (R14)

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			new_osc_q <= OSC_SEL_RST;
		end else if (wr_ok && !switch_q) begin
			new_osc_q <= wr_data_in[NEW_OSC_MSB:NEW_OSC_LSB]; // (R12)
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			switch_q <= 1'b0;
			cnt_q <= 4'h0;
			active_q <= OSC_SEL_RST;
		end else if (switch_q) begin
			if (cnt_q == SWITCH_CNT_MAX) begin
				switch_q <= 1'b0; // (R13)
				active_q <= new_osc_q;
				cnt_q <= 4'h0;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (wr_ok && wr_data_in[SWITCH_REQ_BIT]) begin
			switch_q <= 1'b1; // (R13)
		end
	end

	assign active_osc_out = active_q;
	always_comb begin
		osc_ctl_out = OSC_CTL_RST;
		osc_ctl_out[NEW_OSC_MSB:NEW_OSC_LSB] = new_osc_q;
		osc_ctl_out[SWITCH_REQ_BIT] = switch_q;
	end
endmodule : osc_switch_ctl

// [logic/power_saving_mode_control.sv]
// Sleep and Idle mode sequencing with clock and peripheral gating
// Functional notes
// (R1) Enter low power only on power-save instruction
// (R2) Sleep stops clocks and halts execution
// (R3) Idle halts CPU, peripherals keep clocking
// (R4) Wake on enabled interrupt, watchdog, reset
// (R5) Sleep shuts down system clock source
// (R6) Clock failure monitor inactive in Sleep
// (R7) Low-power RC runs in Sleep with watchdog
// (R8) Watchdog cleared just before entering Sleep
// (R9) Pin change, external-clock peripherals may wake
// (R10) System-clock peripherals disabled during Sleep
// (R11) Wake resumes on the pre-Sleep clock source; a switch that completes during Sleep wakes on the new source
// (R12) Unlocked software selects new oscillator field
// (R13) Switch request bit cleared when switch done
// (R14) Oscillator register writes need unlock sequence
// (R15) After wake, CPU resumes, interrupt first
`timescale 1ns/10ps
module power_saving_mode_control
	import pwr_ctl_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PWR_SAVE_EXEC_IN,
	input wire logic PWR_SAVE_MODE_IN,
	input wire logic IRQ_ENABLED_PENDING_IN,
	input wire logic IRQ_PRIO_ALLOWS_IN,
	input wire logic PIN_CHANGE_IRQ_IN,
	input wire logic EXT_CLK_PERIPH_IRQ_IN,
	input wire logic WDT_ENABLE_IN,
	input wire logic WDT_TIMEOUT_IN,
	input wire logic FAIL_MONITOR_EN_IN,
	input wire logic OSC_UNLOCKED_IN,
	input wire logic CLK_CFG_LOCKED_IN,
	input wire logic OSC_CTL_WR_IN,
	input wire logic [15:0] OSC_CTL_WDATA_IN,
	output logic CPU_CLK_EN_OUT,
	output logic PERIPH_CLK_EN_OUT,
	output logic SYS_OSC_EN_OUT,
	output logic [2:0] SYS_OSC_SEL_OUT,
	output logic FAIL_MONITOR_ACTIVE_OUT,
	output logic LOW_POWER_RC_EN_OUT,
	output logic WDT_CLEAR_OUT,
	output logic WAKE_OUT,
	output logic VECTOR_TO_IRQ_OUT,
	output logic SLEEPING_OUT,
	output logic IDLING_OUT,
	output logic [15:0] OSC_CTL_RDATA_OUT
);
	pwr_state_t state_q;
	logic wake_evt;
	logic sleep_wake_evt;
	logic wdt_clear_q;
	logic wake_q;
	logic vector_q;
	logic [2:0] active_osc;
	logic [2:0] held_osc_q;
	logic enter_req;
	logic wake_hit;
	logic osc_wr;

	// Clock changes are refused while the core is stopped
	assign osc_wr = OSC_CTL_WR_IN && (state_q == ST_RUN);

	osc_switch_ctl u_osc (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.unlocked_in(OSC_UNLOCKED_IN),
		.cfg_locked_in(CLK_CFG_LOCKED_IN),
		.wr_in(osc_wr),
		.wr_data_in(OSC_CTL_WDATA_IN),
		.active_osc_out(active_osc),
		.osc_ctl_out(OSC_CTL_RDATA_OUT)
	);

	// Device reset itself is the third wake source via RST_IN
	assign wake_evt = IRQ_ENABLED_PENDING_IN || WDT_TIMEOUT_IN; // (R4)
	// Sleep keeps every Idle wake source and adds the asynchronous ones
	assign sleep_wake_evt = wake_evt || PIN_CHANGE_IRQ_IN ||
		EXT_CLK_PERIPH_IRQ_IN; // (R9)

	// Operand decode shared by entry and the watchdog clear
	function automatic logic is_sleep_mode(input logic mode);
		return mode == PS_MODE_SLEEP;
	endfunction : is_sleep_mode

	// Which wake sources still count in the given state
	function automatic logic wake_seen(
		input pwr_state_t st,
		input logic run_evt,
		input logic sleep_evt
	);
		logic hit;
		hit = 1'b0;
		case (st)
			ST_IDLE: begin
				hit = run_evt;
			end
			ST_SLEEP: begin
				hit = sleep_evt;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction : wake_seen

	assign enter_req = (state_q == ST_RUN) && PWR_SAVE_EXEC_IN; // (R1)
	assign wake_hit = wake_seen(state_q, wake_evt, sleep_wake_evt); // (R4)

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_q <= ST_RUN; // (R4)
		end else begin
			case (state_q)
				ST_RUN: begin
					if (enter_req) begin // (R1)
						state_q <= is_sleep_mode(PWR_SAVE_MODE_IN)
							? ST_SLEEP : ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (wake_evt) begin
						state_q <= ST_RUN; // (R4)
					end
				end
				ST_SLEEP: begin
					if (sleep_wake_evt) begin
						state_q <= ST_RUN; // (R4)
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Registered pulse in the first Sleep cycle, one cycle after the entry request
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			wdt_clear_q <= 1'b0;
		end else begin
			wdt_clear_q <= enter_req && is_sleep_mode(PWR_SAVE_MODE_IN) &&
				WDT_ENABLE_IN; // (R8)
		end
	end

	// Source is captured at entry so Sleep and Idle hold it; a wake returns to active_osc
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			held_osc_q <= OSC_SEL_RST;
		end else if (state_q == ST_RUN) begin
			held_osc_q <= active_osc; // (R11)
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_hit; // (R15)
		end
	end

	// Watchdog wakes restart code without taking an interrupt
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			vector_q <= 1'b0;
		end else begin
			vector_q <= wake_hit && !WDT_TIMEOUT_IN &&
				IRQ_PRIO_ALLOWS_IN; // (R15)
		end
	end

	// One decode drives every gate, so no state can leave one stale
	always_comb begin
		CPU_CLK_EN_OUT = 1'b1;
		PERIPH_CLK_EN_OUT = 1'b1;
		SYS_OSC_EN_OUT = 1'b1;
		SYS_OSC_SEL_OUT = active_osc;
		FAIL_MONITOR_ACTIVE_OUT = FAIL_MONITOR_EN_IN;
		SLEEPING_OUT = 1'b0;
		IDLING_OUT = 1'b0;
		case (state_q)
			ST_RUN: begin
				CPU_CLK_EN_OUT = 1'b1;
				PERIPH_CLK_EN_OUT = 1'b1;
				SYS_OSC_EN_OUT = 1'b1;
				SYS_OSC_SEL_OUT = active_osc;
				FAIL_MONITOR_ACTIVE_OUT = FAIL_MONITOR_EN_IN;
				SLEEPING_OUT = 1'b0;
				IDLING_OUT = 1'b0;
			end
			ST_IDLE: begin
				CPU_CLK_EN_OUT = 1'b0; // (R3)
				PERIPH_CLK_EN_OUT = 1'b1; // (R3)
				SYS_OSC_EN_OUT = 1'b1;
				SYS_OSC_SEL_OUT = held_osc_q; // (R11)
				FAIL_MONITOR_ACTIVE_OUT = FAIL_MONITOR_EN_IN;
				SLEEPING_OUT = 1'b0;
				IDLING_OUT = 1'b1;
			end
			ST_SLEEP: begin
				CPU_CLK_EN_OUT = 1'b0; // (R2)
				PERIPH_CLK_EN_OUT = 1'b0; // (R10)
				SYS_OSC_EN_OUT = 1'b0; // (R5)
				SYS_OSC_SEL_OUT = held_osc_q; // (R11)
				FAIL_MONITOR_ACTIVE_OUT = 1'b0; // (R6)
				SLEEPING_OUT = 1'b1;
				IDLING_OUT = 1'b0;
			end
			default: begin
				CPU_CLK_EN_OUT = 1'b0;
				PERIPH_CLK_EN_OUT = 1'b1;
				SYS_OSC_EN_OUT = 1'b1;
				SYS_OSC_SEL_OUT = held_osc_q;
				FAIL_MONITOR_ACTIVE_OUT = FAIL_MONITOR_EN_IN;
				SLEEPING_OUT = 1'b0;
				IDLING_OUT = 1'b0;
			end
		endcase
	end

	assign LOW_POWER_RC_EN_OUT = WDT_ENABLE_IN; // (R7)
	assign WDT_CLEAR_OUT = wdt_clear_q; // (R8)
	assign WAKE_OUT = wake_q;
	assign VECTOR_TO_IRQ_OUT = vector_q;
endmodule : power_saving_mode_control

// [verif/pwr_ctl_checker.sv]
// Port assertions for the power-saving mode controller
`timescale 1ns/10ps
module pwr_ctl_checker (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PWR_SAVE_EXEC_IN,
	input wire logic PWR_SAVE_MODE_IN,
	input wire logic PIN_CHANGE_IRQ_IN,
	input wire logic WDT_ENABLE_IN,
	input wire logic CPU_CLK_EN_OUT,
	input wire logic PERIPH_CLK_EN_OUT,
	input wire logic SYS_OSC_EN_OUT,
	input wire logic LOW_POWER_RC_EN_OUT,
	input wire logic FAIL_MONITOR_ACTIVE_OUT,
	input wire logic WDT_CLEAR_OUT,
	input wire logic WAKE_OUT,
	input wire logic SLEEPING_OUT,
	input wire logic IDLING_OUT,
	input wire logic [2:0] SYS_OSC_SEL_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_go;
		PWR_SAVE_EXEC_IN && !SLEEPING_OUT && !IDLING_OUT;
	endsequence
	property p_slp; s_go ##0 !PWR_SAVE_MODE_IN |=> SLEEPING_OUT; endproperty
	a_slp: assert property (p_slp) else $error("no sleep");
	property p_idl;
		s_go ##0 PWR_SAVE_MODE_IN |=> IDLING_OUT && !CPU_CLK_EN_OUT;
	endproperty
	a_idl: assert property (p_idl) else $error("no idle");
	property p_hold;
		!PWR_SAVE_EXEC_IN && !SLEEPING_OUT && !IDLING_OUT |=> !SLEEPING_OUT;
	endproperty
	a_hold: assert property (p_hold) else $error("stray sleep");
	property p_gate;
		SLEEPING_OUT |-> !(CPU_CLK_EN_OUT || PERIPH_CLK_EN_OUT ||
			SYS_OSC_EN_OUT || FAIL_MONITOR_ACTIVE_OUT);
	endproperty
	a_gate: assert property (p_gate) else $error("gating");
	property p_rc_clk; LOW_POWER_RC_EN_OUT == WDT_ENABLE_IN; endproperty
	a_rc_clk: assert property (p_rc_clk) else $error("rc clock");
	property p_wclr;
		s_go ##0 !PWR_SAVE_MODE_IN && WDT_ENABLE_IN |=>
			WDT_CLEAR_OUT ##1 !WDT_CLEAR_OUT;
	endproperty
	a_wclr: assert property (p_wclr) else $error("wdt clear");
	property p_wake;
		SLEEPING_OUT && PIN_CHANGE_IRQ_IN |=> WAKE_OUT && CPU_CLK_EN_OUT;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_sel;
		SLEEPING_OUT && $past(SLEEPING_OUT) |-> $stable(SYS_OSC_SEL_OUT);
	endproperty
	a_sel: assert property (p_sel) else $error("clock moved");
endmodule : pwr_ctl_checker

// [verif/tb.sv]
// Self-checking bench for the power-saving mode controller
`timescale 1ns/10ps
module tb;
	import pwr_ctl_pkg::*;
	logic CLK_IN = 0, RST_IN = 1, PWR_SAVE_EXEC_IN = 0, PWR_SAVE_MODE_IN = 0;
	logic IRQ_ENABLED_PENDING_IN = 0, IRQ_PRIO_ALLOWS_IN = 1;
	logic PIN_CHANGE_IRQ_IN = 0, EXT_CLK_PERIPH_IRQ_IN = 0, WDT_ENABLE_IN = 1;
	logic WDT_TIMEOUT_IN = 0, FAIL_MONITOR_EN_IN = 1, OSC_UNLOCKED_IN = 0;
	logic CLK_CFG_LOCKED_IN = 0, OSC_CTL_WR_IN = 0;
	logic [15:0] OSC_CTL_WDATA_IN = 16'h0000, OSC_CTL_RDATA_OUT;
	logic CPU_CLK_EN_OUT, PERIPH_CLK_EN_OUT, SYS_OSC_EN_OUT;
	logic LOW_POWER_RC_EN_OUT;
	logic FAIL_MONITOR_ACTIVE_OUT, WDT_CLEAR_OUT, WAKE_OUT, VECTOR_TO_IRQ_OUT;
	logic SLEEPING_OUT, IDLING_OUT;
	logic [2:0] SYS_OSC_SEL_OUT;
	int bad_count = 0, tests_run = 0;
	power_saving_mode_control uut (
		.CLK_IN(CLK_IN),
		.RST_IN(RST_IN),
		.PWR_SAVE_EXEC_IN(PWR_SAVE_EXEC_IN),
		.PWR_SAVE_MODE_IN(PWR_SAVE_MODE_IN),
		.IRQ_ENABLED_PENDING_IN(IRQ_ENABLED_PENDING_IN),
		.IRQ_PRIO_ALLOWS_IN(IRQ_PRIO_ALLOWS_IN),
		.PIN_CHANGE_IRQ_IN(PIN_CHANGE_IRQ_IN),
		.EXT_CLK_PERIPH_IRQ_IN(EXT_CLK_PERIPH_IRQ_IN),
		.WDT_ENABLE_IN(WDT_ENABLE_IN),
		.WDT_TIMEOUT_IN(WDT_TIMEOUT_IN),
		.FAIL_MONITOR_EN_IN(FAIL_MONITOR_EN_IN),
		.OSC_UNLOCKED_IN(OSC_UNLOCKED_IN),
		.CLK_CFG_LOCKED_IN(CLK_CFG_LOCKED_IN),
		.OSC_CTL_WR_IN(OSC_CTL_WR_IN),
		.OSC_CTL_WDATA_IN(OSC_CTL_WDATA_IN),
		.CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
		.PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
		.SYS_OSC_EN_OUT(SYS_OSC_EN_OUT),
		.SYS_OSC_SEL_OUT(SYS_OSC_SEL_OUT),
		.FAIL_MONITOR_ACTIVE_OUT(FAIL_MONITOR_ACTIVE_OUT),
		.LOW_POWER_RC_EN_OUT(LOW_POWER_RC_EN_OUT),
		.WDT_CLEAR_OUT(WDT_CLEAR_OUT),
		.WAKE_OUT(WAKE_OUT),
		.VECTOR_TO_IRQ_OUT(VECTOR_TO_IRQ_OUT),
		.SLEEPING_OUT(SLEEPING_OUT),
		.IDLING_OUT(IDLING_OUT),
		.OSC_CTL_RDATA_OUT(OSC_CTL_RDATA_OUT)
	);
	initial forever #2.5 CLK_IN = ~CLK_IN;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	task cyc(input int n);
		repeat (n) @(negedge CLK_IN);
	endtask : cyc
	task pwr(input logic mode);
		PWR_SAVE_MODE_IN = mode;
		PWR_SAVE_EXEC_IN = 1;
		cyc(1);
		PWR_SAVE_EXEC_IN = 0;
	endtask : pwr
	task wr(input logic [15:0] d);
		OSC_CTL_WDATA_IN = d;
		OSC_CTL_WR_IN = 1;
		cyc(1);
		OSC_CTL_WR_IN = 0;
	endtask : wr
	task t_osc;
		CLK_CFG_LOCKED_IN = 1;
		OSC_UNLOCKED_IN = 1;
		wr(16'h0501);
		chk(OSC_CTL_RDATA_OUT, 16'h0000);
		CLK_CFG_LOCKED_IN = 0;
		OSC_UNLOCKED_IN = 0;
		wr(16'h0501);
		chk(OSC_CTL_RDATA_OUT, 16'h0000);
		OSC_UNLOCKED_IN = 1;
		wr(16'h0301);
		chk(OSC_CTL_RDATA_OUT, 16'h0301);
		cyc(SWITCH_CYCLES - 1);
		chk({OSC_CTL_RDATA_OUT[0], SYS_OSC_SEL_OUT}, 16'h0008);
		cyc(1);
		chk({OSC_CTL_RDATA_OUT[10:8], OSC_CTL_RDATA_OUT[0]}, 16'h0006);
		chk(SYS_OSC_SEL_OUT, 16'h0003);
	endtask : t_osc
	task t_sleep(input logic wdt, input logic ext);
		WDT_ENABLE_IN = wdt;
		pwr(PS_MODE_SLEEP);
		chk({SLEEPING_OUT, CPU_CLK_EN_OUT, SYS_OSC_EN_OUT}, 16'h0004);
		chk({LOW_POWER_RC_EN_OUT, WDT_CLEAR_OUT}, {wdt, wdt});
		chk(SYS_OSC_SEL_OUT, 16'h0003);
		pwr(PS_MODE_IDLE);
		chk({SLEEPING_OUT, IDLING_OUT, PERIPH_CLK_EN_OUT}, 16'h0004);
		chk({FAIL_MONITOR_ACTIVE_OUT, SYS_OSC_EN_OUT}, 16'h0000);
		PIN_CHANGE_IRQ_IN = !ext;
		EXT_CLK_PERIPH_IRQ_IN = ext;
		cyc(1);
		PIN_CHANGE_IRQ_IN = 0;
		EXT_CLK_PERIPH_IRQ_IN = 0;
		chk({SLEEPING_OUT, WAKE_OUT, SYS_OSC_SEL_OUT}, 16'h000B);
	endtask : t_sleep
	task t_idle(input logic wdt, input logic prio);
		logic vec;
		vec = !wdt && prio;
		IRQ_PRIO_ALLOWS_IN = prio;
		pwr(PS_MODE_IDLE);
		chk({IDLING_OUT, CPU_CLK_EN_OUT, PERIPH_CLK_EN_OUT}, 16'h0005);
		chk({FAIL_MONITOR_ACTIVE_OUT, SYS_OSC_EN_OUT}, 16'h0003);
		WDT_TIMEOUT_IN = wdt;
		IRQ_ENABLED_PENDING_IN = !wdt;
		cyc(1);
		WDT_TIMEOUT_IN = 0;
		IRQ_ENABLED_PENDING_IN = 0;
		chk({IDLING_OUT, WAKE_OUT, VECTOR_TO_IRQ_OUT}, {2'b01, vec});
	endtask : t_idle
	// Reset in Sleep, then a watchdog wake from a fresh Sleep
	task t_reset;
		pwr(PS_MODE_SLEEP);
		RST_IN = 1;
		cyc(2);
		chk({SLEEPING_OUT, CPU_CLK_EN_OUT, SYS_OSC_SEL_OUT}, 16'h0008);
		RST_IN = 0;
		cyc(1);
		pwr(PS_MODE_SLEEP);
		chk({SLEEPING_OUT, WAKE_OUT}, 16'h0002);
		WDT_TIMEOUT_IN = 1;
		cyc(1);
		WDT_TIMEOUT_IN = 0;
		chk({SLEEPING_OUT, WAKE_OUT, VECTOR_TO_IRQ_OUT}, 16'h0002);
	endtask : t_reset
	initial begin
		cyc(6);
		chk({CPU_CLK_EN_OUT, SLEEPING_OUT, WAKE_OUT}, 16'h0004);
		RST_IN = 0;
		cyc(1);
		t_osc;
		t_sleep(1, 0);
		t_sleep(0, 1);
		t_idle(0, 1);
		t_idle(1, 1);
		t_idle(0, 0);
		t_reset;
		test_done;
	end
	// Whole run is about 38 cycles
	initial begin
		#5000;
		bad_count++;
		test_done;
	end
endmodule : tb
bind power_saving_mode_control pwr_ctl_checker chk_i (
	.CLK_IN(CLK_IN),
	.RST_IN(RST_IN),
	.PWR_SAVE_EXEC_IN(PWR_SAVE_EXEC_IN),
	.PWR_SAVE_MODE_IN(PWR_SAVE_MODE_IN),
	.PIN_CHANGE_IRQ_IN(PIN_CHANGE_IRQ_IN),
	.WDT_ENABLE_IN(WDT_ENABLE_IN),
	.CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
	.PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
	.SYS_OSC_EN_OUT(SYS_OSC_EN_OUT),
	.LOW_POWER_RC_EN_OUT(LOW_POWER_RC_EN_OUT),
	.FAIL_MONITOR_ACTIVE_OUT(FAIL_MONITOR_ACTIVE_OUT),
	.WDT_CLEAR_OUT(WDT_CLEAR_OUT),
	.WAKE_OUT(WAKE_OUT),
	.SLEEPING_OUT(SLEEPING_OUT),
	.IDLING_OUT(IDLING_OUT),
	.SYS_OSC_SEL_OUT(SYS_OSC_SEL_OUT)
);
